// ### include/dancer_pkg.sv
// Package: register map, codes, reset values and timing of the dancer block
package dancer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ACT_SEL   = 8'h00;
  localparam logic [7:0] OFS_IN_FUNC0  = 8'h04;
  localparam logic [7:0] OFS_IN_FUNC1  = 8'h08;
  localparam logic [7:0] OFS_OUT_FUNC  = 8'h0C;
  localparam logic [7:0] OFS_MEAS_TYPE = 8'h10;
  localparam logic [7:0] OFS_UPPER     = 8'h14;
  localparam logic [7:0] OFS_LOWER     = 8'h18;
  localparam logic [7:0] OFS_SETPT     = 8'h1C;
  localparam logic [7:0] OFS_RAMP2     = 8'h20;
  localparam logic [7:0] OFS_NET_BITS  = 8'h24;
  localparam logic [7:0] OFS_OP_MODE   = 8'h28;
  localparam logic [7:0] OFS_PANEL_SPD = 8'h2C;
  localparam logic [7:0] OFS_NET_SPD   = 8'h30;
  localparam logic [7:0] OFS_GAIN      = 8'h34;
  localparam logic [7:0] OFS_STATUS    = 8'h38;
  localparam logic [7:0] OFS_SPEED     = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h44;
  // Action selection range and function codes
  localparam logic [7:0]  ACT_OFF      = 8'h00;
  localparam logic [7:0]  ACT_FIRST    = 8'h28;
  localparam logic [7:0]  ACT_LAST     = 8'h2B;
  localparam logic [7:0]  FN_ENABLE_IN = 8'h0E;
  localparam logic [7:0]  FN_LOWER     = 8'h0E;
  localparam logic [7:0]  FN_UPPER     = 8'h0F;
  localparam logic [7:0]  FN_DIR       = 8'h10;
  localparam logic [7:0]  FN_PID       = 8'h2F;
  localparam logic [7:0]  FN_NEG_BASE  = 8'h64;
  // Settings in 0.1 % steps; the disable marker and the default set point
  localparam logic [13:0] SET_NONE     = 14'h270F;
  localparam logic [13:0] SET_HALF     = 14'h01F4;
  localparam logic [10:0] PCT_FULL     = 11'h3E8;
  // Measured input types and 12-bit converter codes
  localparam logic [1:0]  MT_4_20MA    = 2'h0;
  localparam logic [1:0]  MT_0_5V      = 2'h1;
  localparam logic [1:0]  MT_0_10V     = 2'h2;
  localparam logic [11:0] RAW_4MA      = 12'h333;
  localparam logic [15:0] K_4_20MA     = 16'h4E25;
  localparam logic [15:0] K_0_5V       = 16'h7D00;
  localparam logic [15:0] K_0_10V      = 16'h3E84;
  // Operation modes of the main speed source
  localparam logic [1:0]  OP_EXT       = 2'h0;
  localparam logic [1:0]  OP_PANEL     = 2'h1;
  localparam logic [1:0]  OP_NET       = 2'h2;
  // Reset values
  localparam logic [31:0] RST_IN_FUNC  = 32'h0000_0000;
  localparam logic [23:0] RST_OUT_FUNC = 24'h00_0000;
  localparam logic [7:0]  RST_GAIN     = 8'h10;
  localparam logic [15:0] RST_STEP     = 16'h0001;
  // Ramp update period
  localparam int CLK_NS       = 8;
  localparam int RAMP_TICK_NS = 1000000;
  localparam int RAMP_TICK_CY = RAMP_TICK_NS / CLK_NS;
endpackage

// ### rtl/meas_scale.sv
// Scales the raw dancer position code to 0.1 % steps by input type
`timescale 1ns/1ps
module meas_scale
  import dancer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Raw code and type
  input  wire logic [11:0] raw,
  input  wire logic [1:0]  mtype,
  // Scaled measurement
  output      logic [10:0] pct_ff
);
  logic [11:0] span;
  logic [15:0] gain_k;
  logic [27:0] prod;
  logic [11:0] scaled;

  // Offset removal and gain per type; current loop starts at 4 mA
  always_comb begin
    span   = raw;
    gain_k = K_0_10V;
    case (mtype)
      MT_4_20MA: begin
        span   = (raw > RAW_4MA) ? 12'(raw - RAW_4MA) : 12'h000;
        gain_k = K_4_20MA;
      end
      MT_0_5V:  gain_k = K_0_5V;
      default:  gain_k = K_0_10V;
    endcase
    prod   = 28'(span * gain_k);
    scaled = prod[27:16];
  end

  // Clamp to full scale; above 5 V on the 5 V range reads as 100 %
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pct_ff <= 11'h000;
    end else begin
      pct_ff <= (scaled > 12'(PCT_FULL)) ? PCT_FULL : scaled[10:0];
    end
  end
endmodule

// ### rtl/speed_ramp.sv
// Ramps the main speed command toward its target on each tick
`timescale 1ns/1ps
module speed_ramp (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        tick,
  input  wire logic        en,
  input  wire logic [15:0] target,
  input  wire logic [15:0] up_step,
  input  wire logic [15:0] dn_step,
  // Ramped value
  output      logic [15:0] ramp_ff
);
  logic [15:0] nxt_ramp;

  // Disabled: follow the target at once so a later start has no jump
  always_comb begin
    nxt_ramp = ramp_ff;
    if (!en) begin
      nxt_ramp = target;
    end else if (tick) begin
      if (target > ramp_ff) begin
        nxt_ramp = (16'(target - ramp_ff) > up_step) ?
                   16'(ramp_ff + up_step) : target;
      end else if (target < ramp_ff) begin
        nxt_ramp = (16'(ramp_ff - target) > dn_step) ?
                   16'(ramp_ff - dn_step) : target;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_ff <= 16'h0000;
    end else begin
      ramp_ff <= nxt_ramp;
    end
  end
endmodule

// ### rtl/dancer_control_supervisor.sv
// Dancer control supervisor: enable logic, correction, flags, register slave
`timescale 1ns/1ps
// How it works
// - Dancer control needs action selection 40..43
// - Input function code 14 maps enable input
// - Unmapped enable: action selection alone decides
// - Selection 0 or enable off: plain drive
// - Active: correction added to main speed
// - Main speed from external, panel or network
// - Position scaled by measured input type
// - Set point from setting, 0 to 100%
// - Upper flag when measurement exceeds limit
// - Lower flag when measurement below limit
// - Direction flag on only for forward rotation
// - PID-active flag on during dancer control
// - Output codes 100 and up invert
// - Second accel/decel ramp main speed command
// - Network bit ORed into a mapped enable input
// - Set point 9999 means fixed 50%
module dancer_control_supervisor
  import dancer_pkg::*;
#(
  parameter int TICK_CY = RAMP_TICK_CY
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register bus
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // Drive side inputs
  input  wire logic [4:0]  term_in,
  input  wire logic [11:0] meas_raw,
  input  wire logic [15:0] ext_speed,
  input  wire logic        run_fwd,
  // Drive side outputs
  output      logic [2:0]  out_term,
  output      logic [15:0] speed_cmd,
  output      logic        irq
);
  typedef struct packed {
    logic [7:0]  act_sel;
    logic [39:0] in_func;
    logic [23:0] out_func;
    logic [1:0]  meas_type;
    logic [13:0] upper;
    logic [13:0] lower;
    logic [13:0] setpt;
    logic [31:0] ramp2;
    logic [4:0]  net_bits;
    logic [1:0]  op_mode;
    logic [15:0] panel_spd;
    logic [15:0] net_spd;
    logic [7:0]  gain;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        wait_n;
    logic [31:0] rdata;
    logic        active;
    logic        up_flag;
    logic        dn_flag;
    logic        dir_flag;
    logic [2:0]  out_term;
    logic [15:0] cmd;
    logic        irq;
    logic [16:0] tick_cnt;
    logic        tick;
  } state_t;

  state_t      st_ff;
  state_t      nxt_st;
  logic [10:0] meas_pct;
  logic [15:0] ramp_val;
  logic        mapped;
  logic        en_level;
  logic        sel_ok;
  logic [13:0] sp_eff;
  logic [15:0] main_spd;
  logic signed [11:0] err;
  logic signed [20:0] corr;
  logic signed [21:0] sum;
  logic [3:0]  ev;

  // One output terminal: pick the flag by code, invert for codes of 100 up
  function automatic logic term_level(input logic [7:0] code,
                                      input logic up, input logic dn,
                                      input logic dir, input logic pid);
    logic [7:0] base;
    logic       v;
    base = (code >= FN_NEG_BASE) ? 8'(code - FN_NEG_BASE) : code;
    case (base)
      FN_LOWER: v = dn;
      FN_UPPER: v = up;
      FN_DIR:   v = dir;
      FN_PID:   v = pid;
      default:  v = 1'b0;
    endcase
    return (code >= FN_NEG_BASE) ? ~v : v;
  endfunction

  // Dancer position in 0.1 % steps
  meas_scale u_scale (
    .clk    (clk),
    .rst    (rst),
    .raw    (meas_raw),
    .mtype  (st_ff.meas_type),
    .pct_ff (meas_pct)
  );

  // Main speed ramp on the second accel/decel steps while active
  speed_ramp u_ramp (
    .clk     (clk),
    .rst     (rst),
    .tick    (st_ff.tick),
    .en      (st_ff.active),
    .target  (main_spd),
    .up_step (st_ff.ramp2[15:0]),
    .dn_step (st_ff.ramp2[31:16]),
    .ramp_ff (ramp_val)
  );

  // Enable mapping, set point and main speed source
  always_comb begin
    mapped   = 1'b0;
    en_level = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (st_ff.in_func[i*8 +: 8] == FN_ENABLE_IN) begin
        mapped   = 1'b1;
        en_level = en_level | term_in[i] | st_ff.net_bits[i];
      end
    end
    sel_ok = (st_ff.act_sel >= ACT_FIRST) &&
             (st_ff.act_sel <= ACT_LAST);
    sp_eff = (st_ff.setpt == SET_NONE) ? SET_HALF : st_ff.setpt;
    case (st_ff.op_mode)
      OP_PANEL: main_spd = st_ff.panel_spd;
      OP_NET:   main_spd = st_ff.net_spd;
      default:  main_spd = ext_speed;
    endcase
  end

  // Proportional correction; even selections act forward, odd reverse
  always_comb begin
    err  = 12'($signed({1'b0, sp_eff[10:0]}) - $signed({1'b0, meas_pct}));
    corr = 21'(err * $signed({1'b0, st_ff.gain})) >>> 4;
    if (st_ff.act_sel[0]) begin
      corr = -corr;
    end
    sum = 22'($signed({6'h00, ramp_val}) + corr);
  end

  // Next state: bus slave, settings, flags, outputs and interrupts
  always_comb begin
    nxt_st = st_ff;
    // Ramp tick divider
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt >= 17'(TICK_CY - 1)) begin
      nxt_st.tick_cnt = 17'h00000;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = 17'(st_ff.tick_cnt + 17'h00001);
    end
    // Active: selection in range, and enable input on if one is mapped
    nxt_st.active = sel_ok && (!mapped || en_level);
    // Limit and direction flags follow their conditions each cycle
    nxt_st.up_flag = sel_ok && (st_ff.upper != SET_NONE) &&
                     ({3'h0, meas_pct} > st_ff.upper);
    nxt_st.dn_flag = sel_ok && (st_ff.lower != SET_NONE) &&
                     ({3'h0, meas_pct} < st_ff.lower);
    nxt_st.dir_flag = run_fwd;
    for (int j = 0; j < 3; j++) begin
      nxt_st.out_term[j] = term_level(st_ff.out_func[j*8 +: 8],
        nxt_st.up_flag, nxt_st.dn_flag, nxt_st.dir_flag,
        nxt_st.active);
    end
    // Command: main speed while inactive, else ramped main speed plus correction, clamped to range
    if (!st_ff.active) begin
      nxt_st.cmd = main_spd;
    end else if (sum < 0) begin
      nxt_st.cmd = 16'h0000;
    end else if (sum > 22'sh00FFFF) begin
      nxt_st.cmd = 16'hFFFF;
    end else begin
      nxt_st.cmd = sum[15:0];
    end
    // Events: upper rise, lower rise, control start, control end
    ev = {st_ff.active & ~nxt_st.active, ~st_ff.active & nxt_st.active,
          ~st_ff.dn_flag & nxt_st.dn_flag, ~st_ff.up_flag & nxt_st.up_flag};
    // Bus: one wait cycle, then the access completes with waitrequest low
    nxt_st.wait_n = 1'b0;
    if ((read || write) && !st_ff.wait_n) begin
      nxt_st.wait_n = 1'b1;
      nxt_st.rdata  = 32'h0000_0000;
      case (address)
        OFS_ACT_SEL:   nxt_st.rdata = {24'h0, st_ff.act_sel};
        OFS_IN_FUNC0:  nxt_st.rdata = st_ff.in_func[31:0];
        OFS_IN_FUNC1:  nxt_st.rdata = {24'h0, st_ff.in_func[39:32]};
        OFS_OUT_FUNC:  nxt_st.rdata = {8'h0, st_ff.out_func};
        OFS_MEAS_TYPE: nxt_st.rdata = {30'h0, st_ff.meas_type};
        OFS_UPPER:     nxt_st.rdata = {18'h0, st_ff.upper};
        OFS_LOWER:     nxt_st.rdata = {18'h0, st_ff.lower};
        OFS_SETPT:     nxt_st.rdata = {18'h0, st_ff.setpt};
        OFS_RAMP2:     nxt_st.rdata = st_ff.ramp2;
        OFS_NET_BITS:  nxt_st.rdata = {27'h0, st_ff.net_bits};
        OFS_OP_MODE:   nxt_st.rdata = {30'h0, st_ff.op_mode};
        OFS_PANEL_SPD: nxt_st.rdata = {16'h0, st_ff.panel_spd};
        OFS_NET_SPD:   nxt_st.rdata = {16'h0, st_ff.net_spd};
        OFS_GAIN:      nxt_st.rdata = {24'h0, st_ff.gain};
        OFS_STATUS:    nxt_st.rdata = {5'h0, meas_pct, 9'h0, st_ff.out_term,
                         st_ff.dir_flag, st_ff.dn_flag, st_ff.up_flag,
                         st_ff.active};
        OFS_SPEED:     nxt_st.rdata = {16'h0, st_ff.cmd};
        OFS_IRQ_STAT:  nxt_st.rdata = {28'h0, st_ff.irq_stat};
        OFS_IRQ_MASK:  nxt_st.rdata = {28'h0, st_ff.irq_mask};
        default:       nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land at the edge that sees waitrequest low
    if (write && st_ff.wait_n) begin
      case (address)
        OFS_ACT_SEL:   nxt_st.act_sel         = writedata[7:0];
        OFS_IN_FUNC0:  nxt_st.in_func[31:0]   = writedata;
        OFS_IN_FUNC1:  nxt_st.in_func[39:32]  = writedata[7:0];
        OFS_OUT_FUNC:  nxt_st.out_func        = writedata[23:0];
        OFS_MEAS_TYPE: nxt_st.meas_type       = writedata[1:0];
        OFS_UPPER:     nxt_st.upper           = writedata[13:0];
        OFS_LOWER:     nxt_st.lower           = writedata[13:0];
        OFS_SETPT:     nxt_st.setpt           = writedata[13:0];
        OFS_RAMP2:     nxt_st.ramp2           = writedata;
        OFS_NET_BITS:  nxt_st.net_bits        = writedata[4:0];
        OFS_OP_MODE:   nxt_st.op_mode         = writedata[1:0];
        OFS_PANEL_SPD: nxt_st.panel_spd       = writedata[15:0];
        OFS_NET_SPD:   nxt_st.net_spd         = writedata[15:0];
        OFS_GAIN:      nxt_st.gain            = writedata[7:0];
        OFS_IRQ_STAT:  nxt_st.irq_stat = st_ff.irq_stat & ~writedata[3:0];
        OFS_IRQ_MASK:  nxt_st.irq_mask        = writedata[3:0];
        default:       nxt_st.gain            = st_ff.gain;
      endcase
    end
    // Set after clear so an event in the clearing cycle is kept
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);
  end

  // All state but the scaler and ramp registers in one register; action selection and limits start off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff           <= '0;
      st_ff.act_sel   <= ACT_OFF;
      st_ff.in_func   <= {8'h00, RST_IN_FUNC};
      st_ff.out_func  <= RST_OUT_FUNC;
      st_ff.meas_type <= MT_4_20MA;
      st_ff.upper     <= SET_NONE;
      st_ff.lower     <= SET_NONE;
      st_ff.setpt     <= SET_NONE;
      st_ff.ramp2     <= {RST_STEP, RST_STEP};
      st_ff.op_mode   <= OP_EXT;
      st_ff.gain      <= RST_GAIN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata    = st_ff.rdata;
  assign waitrequest = ~st_ff.wait_n;
  assign out_term    = st_ff.out_term;
  assign speed_cmd   = st_ff.cmd;
  assign irq         = st_ff.irq;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_active_range: assert property (
    st_ff.active |-> ($past(st_ff.act_sel) inside {[40:43]}))
    else $error("dancer active outside selection range");
  chk_unmapped_sel: assert property (
    (!mapped && sel_ok) |=> st_ff.active)
    else $error("unmapped enable did not allow control");
  chk_enable_off: assert property (
    (mapped && !en_level) |=> (!st_ff.active ##1
      (st_ff.cmd == $past(main_spd))))
    else $error("control or correction with enable off");
  chk_upper_flag: assert property (
    (sel_ok && st_ff.upper != 14'd9999 && meas_pct > st_ff.upper[10:0]
     && st_ff.upper < 14'd1000) |=> st_ff.up_flag)
    else $error("upper flag missing");
  chk_lower_none: assert property (
    (st_ff.lower == 14'd9999) |=> !st_ff.dn_flag)
    else $error("lower flag set while disabled");
  chk_dir_follow: assert property (
    run_fwd[*2] |=> st_ff.dir_flag)
    else $error("direction flag off during forward run");
  chk_pid_out: assert property (
    ($past(st_ff.out_func[7:0]) == 8'd47) |-> out_term[0] == st_ff.active)
    else $error("pid output does not follow control");
  chk_neg_out: assert property (
    ($past(st_ff.out_func[7:0]) == 8'd147) |-> out_term[0] != st_ff.active)
    else $error("negative logic output not inverted");
  chk_half_setpt: assert property (
    (st_ff.setpt == 14'd9999) |-> sp_eff == 14'd500)
    else $error("default set point not half scale");
  chk_bus_answer: assert property (
    (read || write) |-> ##[0:1] !waitrequest)
    else $error("bus access not answered");
  chk_irq_level: assert property (
    irq == |(st_ff.irq_stat & st_ff.irq_mask))
    else $error("interrupt output mismatch");

  // Flags, enable, command and ramp tick against their conditions
  chk_lower_flag: assert property (
    (sel_ok && st_ff.lower != SET_NONE && {3'h0, meas_pct} < st_ff.lower)
    |=> st_ff.dn_flag)
    else $error("lower flag missing");
  chk_upper_none: assert property (
    (st_ff.upper == SET_NONE) |=> !st_ff.up_flag)
    else $error("upper flag set while disabled");
  chk_map_enable: assert property (
    (sel_ok && mapped && en_level) |=> st_ff.active)
    else $error("mapped enable on did not allow control");
  chk_sel_off: assert property (
    (st_ff.act_sel == ACT_OFF) |=> !st_ff.active)
    else $error("control active with selection off");
  chk_inactive_cmd: assert property (
    !st_ff.active |=> (st_ff.cmd == $past(main_spd)))
    else $error("correction applied while control inactive");
  chk_dir_off: assert property (
    !run_fwd |=> !st_ff.dir_flag)
    else $error("direction flag on without forward run");
  chk_tick_pulse: assert property (
    st_ff.tick |=> !st_ff.tick)
    else $error("ramp tick longer than one cycle");

  cov_active: cover property ($rose(st_ff.active));
  cov_upper: cover property ($rose(st_ff.up_flag));
  cov_net_en: cover property (mapped && $rose(|st_ff.net_bits) ##1
                              st_ff.active);
  cov_lower: cover property ($rose(st_ff.dn_flag));
  cov_neg_pid: cover property ((st_ff.out_func[7:0] == 8'h93) && st_ff.active);
endmodule

// ### test/dancer_detector.sv
// Dancer roller position detector model: roller position to converter code
`timescale 1ns/1ps
module dancer_detector
  import dancer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Roller position in 0.1 % steps and selected input type
  input  wire logic [10:0] pos,
  input  wire logic [1:0]  mtype,
  // Converter code seen by the drive
  output      logic [11:0] raw
);
  // One sample of lag, so the drive never sees a same-edge position change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw <= 12'h000;
    end else begin
      case (mtype)
        MT_4_20MA: raw <= 12'(32'(RAW_4MA) + 32'(pos) * 3276 / 1000);
        MT_0_5V:   raw <= 12'(32'(pos) * 2048 / 1000);
        default:   raw <= 12'(32'(pos) * 4095 / 1000);
      endcase
    end
  end
endmodule

// ### test/dancer_control_supervisor_bench.sv
// Self-checking bench for the dancer control supervisor
`timescale 1ns/1ps
module dancer_control_supervisor_bench
  import dancer_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [4:0]  term_in = 5'h00;
  logic [11:0] meas_raw;
  logic [15:0] ext_speed = 16'h0000;
  logic        run_fwd = 1'b0;
  logic [2:0]  out_term;
  logic [15:0] speed_cmd;
  logic        irq;
  logic [10:0] pos = 11'h000;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [31:0] infn;
  logic [7:0]  m_act;
  logic [1:0]  m_type;
  logic [4:0]  m_map;
  logic [4:0]  m_net;
  int          m_up, m_lo, n_errors, n_compared, i, k;
  int          m_fn[3];
  int          acts[8] = '{0, 39, 40, 41, 42, 43, 44, 255};
  int          fns[8] = '{14, 15, 16, 47, 114, 115, 116, 147};
  logic [7:0]  roff[6] = '{OFS_ACT_SEL, OFS_UPPER, OFS_LOWER, OFS_SETPT,
                           OFS_RAMP2, OFS_GAIN};
  logic [31:0] rval[6] = '{32'h0, 32'h270F, 32'h270F, 32'h270F,
                           32'h0001_0001, 32'h10};

  dancer_control_supervisor #(.TICK_CY(4)) dancer_control_supervisor_i (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .term_in(term_in), .meas_raw(meas_raw), .ext_speed(ext_speed),
    .run_fwd(run_fwd), .out_term(out_term), .speed_cmd(speed_cmd),
    .irq(irq));
  dancer_detector dancer_detector_i (
    .clk(clk), .rst(rst), .pos(pos), .mtype(m_type), .raw(meas_raw));

  // 125 MHz clock
  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Read answers are judged here, oldest expectation first
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      chk(readdata, exp_q.pop_front());
    end
  end

  // One Avalon access; held until waitrequest is seen low, bounded wait
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 64) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Expected status word from the bench's own view of the settings
  function automatic logic [31:0] exp_stat();
    int p, f, j;
    logic s, a, u, d, v;
    logic [2:0] ot;
    // Gains are 16-bit fractions; flooring the same way avoids off-by-one
    case (m_type)
      MT_4_20MA: p = (int'(meas_raw) - int'(RAW_4MA)) * int'(K_4_20MA);
      MT_0_5V:   p = int'(meas_raw) * int'(K_0_5V);
      default:   p = int'(meas_raw) * int'(K_0_10V);
    endcase
    p = (p < 0) ? 0 : p / 65536;
    if (p > 1000) p = 1000;
    s = m_act >= ACT_FIRST && m_act <= ACT_LAST;
    a = s && (m_map == 5'h00 || (m_map & (term_in | m_net)) != 5'h00);
    u = s && m_up != SET_NONE && p > m_up;
    d = s && m_lo != SET_NONE && p < m_lo;
    for (j = 0; j < 3; j++) begin
      f = m_fn[j] % 100;
      v = f == 15 ? u : f == 14 ? d : f == 16 ? run_fwd : f == 47 ? a : 1'b0;
      ot[j] = m_fn[j] >= 100 ? !v : v;
    end
    return {5'h00, p[10:0], 9'h000, ot, run_fwd, d, u, a};
  endfunction

  initial begin
    void'($urandom(2));
    m_act = ACT_OFF;
    m_type <= MT_4_20MA;
    m_map = 5'h00;
    m_net = 5'h00;
    m_up = SET_NONE;
    m_lo = SET_NONE;
    m_fn = '{0, 0, 0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then an unmapped address that must stay empty
    for (i = 0; i < 6; i++) rd(roff[i], rval[i]);
    wr(8'h48, 32'hFFFF_FFFF);
    rd(8'h48, 32'h0000_0000);
    rd(OFS_STATUS, exp_stat());
    $display("test reset done");
    // Control start raises a sticky, maskable interrupt
    wr(OFS_IRQ_STAT, 32'hFFFF_FFFF);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    chk(32'(irq), 32'h0);
    wr(OFS_ACT_SEL, 32'h0000_0028);
    cyc(4);
    chk(32'(irq), 32'h1);
    rd(OFS_IRQ_STAT, 32'h0000_0004);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    wr(OFS_IRQ_STAT, 32'h0000_0004);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_ACT_SEL, 32'h0000_0000);
    $display("test interrupt done");
    // Main speed source per mode, then ramp and correction
    ext_speed <= 16'h1388;
    wr(OFS_PANEL_SPD, 32'h0000_0BB8);
    wr(OFS_NET_SPD, 32'h0000_0FA0);
    for (i = 0; i < 3; i++) begin
      wr(OFS_OP_MODE, 32'(i));
      cyc(4);
      rd(OFS_SPEED, i == 0 ? 32'h1388 : i == 1 ? 32'h0BB8 : 32'h0FA0);
    end
    wr(OFS_OP_MODE, 32'h0000_0000);
    wr(OFS_RAMP2, 32'h0032_0064);
    m_type <= MT_0_5V;
    pos <= 11'h1F4;
    wr(OFS_MEAS_TYPE, 32'h0000_0001);
    wr(OFS_ACT_SEL, 32'h0000_0028);
    cyc(8);
    rd(OFS_SPEED, 32'h0000_1388);
    // Main speed steps at once, as with zero primary ramp times
    ext_speed <= 16'h1770;
    cyc(12);
    chk(32'(speed_cmd > 16'h1388 && speed_cmd < 16'h1770), 32'h1);
    cyc(60);
    rd(OFS_SPEED, 32'h0000_1770);
    ext_speed <= 16'h1388;
    cyc(12);
    chk(32'(speed_cmd > 16'h1388 && speed_cmd < 16'h1770), 32'h1);
    cyc(100);
    rd(OFS_SPEED, 32'h0000_1388);
    pos <= 11'h000;
    cyc(4);
    rd(OFS_SPEED, 32'h0000_157C);
    wr(OFS_ACT_SEL, 32'h0000_0029);
    cyc(4);
    rd(OFS_SPEED, 32'h0000_1194);
    wr(OFS_ACT_SEL, 32'h0000_0028);
    wr(OFS_SETPT, 32'h0000_00C8);
    cyc(4);
    rd(OFS_SPEED, 32'h0000_1450);
    wr(OFS_IN_FUNC1, 32'(FN_ENABLE_IN));
    cyc(4);
    rd(OFS_SPEED, 32'h0000_1388);
    wr(OFS_NET_BITS, 32'h0000_0010);
    cyc(4);
    rd(OFS_SPEED, 32'h0000_1450);
    wr(OFS_NET_BITS, 32'h0000_0000);
    wr(OFS_IN_FUNC1, 32'h0000_0000);
    $display("test speed done");
    // Random settings: enable, scaling, limits, flags and polarity
    for (k = 0; k < 40; k++) begin
      m_act = 8'(acts[$urandom % 8]);
      m_type <= 2'($urandom % 3);
      m_up = ($urandom % 4 == 0) ? int'(SET_NONE) : int'($urandom % 1001);
      m_lo = ($urandom % 4 == 0) ? int'(SET_NONE) : int'($urandom % 1001);
      m_map = ($urandom % 3 == 0) ? 5'h00 : 5'($urandom);
      m_net = 5'($urandom);
      for (i = 0; i < 3; i++) m_fn[i] = fns[$urandom % 8];
      infn = 32'h0000_0000;
      for (i = 0; i < 4; i++) if (m_map[i]) infn[8*i +: 8] = FN_ENABLE_IN;
      term_in <= 5'($urandom);
      run_fwd <= 1'($urandom);
      pos <= 11'($urandom % 1001);
      wr(OFS_ACT_SEL, 32'(m_act));
      wr(OFS_MEAS_TYPE, 32'(m_type));
      wr(OFS_UPPER, 32'(m_up));
      wr(OFS_LOWER, 32'(m_lo));
      wr(OFS_IN_FUNC0, infn);
      wr(OFS_IN_FUNC1, m_map[4] ? 32'(FN_ENABLE_IN) : 32'h0);
      wr(OFS_NET_BITS, 32'(m_net));
      wr(OFS_OUT_FUNC, {8'h00, 8'(m_fn[2]), 8'(m_fn[1]), 8'(m_fn[0])});
      cyc(6);
      e = exp_stat();
      rd(OFS_STATUS, e);
      chk(32'(out_term), 32'(e[6:4]));
    end
    $display("test random done");
    test_done();
  end
endmodule
